// File: verilog/bcm_params.svh
`ifndef BCM_PARAMS_SVH
`define BCM_PARAMS_SVH
// ==========================================
// Register offsets
`define BCM_ADDR_MODE 8'h61
`define BCM_ADDR_CEIL 8'h62
`define BCM_ADDR_SUPPLY 8'h6D
`define BCM_ADDR_HEAT 8'h6E
// ==========================================
// Field positions
`define BCM_MODE_MSB 6
`define BCM_MODE_LSB 4
`define BCM_TDEG_MSB 2
`define BCM_CEIL_MSB 3
`define BCM_MEAS_MSB 9
// ==========================================
// Reset values
`define BCM_MODE_RST 3'h2
`define BCM_TDEG_RST 3'h6
`define BCM_CEIL_RST 4'h8
`define BCM_SUPPLY_RST 10'h263
`define BCM_HEAT_RST 10'h19
// ==========================================
// Timing
`define BCM_CLK_MHZ 200
`define BCM_TDEG0_US 1330
`define BCM_TDEG1_US 2660
`define BCM_TDEG2_US 5320
`define BCM_TDEG3_US 21300
`define BCM_TDEG4_US 85200
`define BCM_TDEG5_US 340790
`define BCM_TDEG6_US 1363000
`define BCM_TDEG7_US 2730000
`endif

// File: verilog/bcm_pkg.sv
package bcm_pkg;
  // ==========================================
  // Types
  typedef enum logic [2:0] {
    BCM_MODE_PASS = 3'h0,
    BCM_MODE_FORCE = 3'h1,
    BCM_MODE_ADAPT1 = 3'h5,
    BCM_MODE_ADAPT2 = 3'h6
  } bcm_mode_type;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } bcm_regbus_type;

  typedef struct packed {
    logic [2:0] converter_operating_select;
    logic [2:0] small_signal_qualify_time;
    logic [3:0] rail_ceiling_code;
    logic raise_rail;
  } bcm_boost_type;
endpackage

// File: verilog/bcm_i2c_slave.sv
`timescale 1ns/10ps
`include "bcm_params.svh"
module bcm_i2c_slave
  import bcm_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A
)
(
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_out,
  output bcm_regbus_type bus_out,
  output logic [7:0] rd_addr_out,
  input wire logic [15:0] rd_data_in
);
  // ==========================================
  // Pin synchronisers
  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_RACK} bcm_i2c_state_type;
  logic [5:0] sync_reg;
  logic [5:0] sync_next;
  logic scl_s;
  logic scl_d;
  logic sda_s;
  logic sda_d;
  bcm_i2c_state_type st_reg, st_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next;
  logic [1:0] byte_reg, byte_next;
  logic rw_reg, rw_next;
  logic [7:0] addr_reg, addr_next;
  logic [7:0] hi_reg, hi_next;
  logic oe_reg, oe_next;
  bcm_regbus_type bus_reg, bus_next;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic load;

  // Bits 5:4 and 2:1 are the first and second stages; 3 and 0 hold history.
  assign scl_s = sync_reg[4];
  assign scl_d = sync_reg[3];
  assign sda_s = sync_reg[1];
  assign sda_d = sync_reg[0];
  assign rise = scl_s && !scl_d;
  assign fall = !scl_s && scl_d;
  assign start = scl_s && scl_d && sda_d && !sda_s;
  assign stop = scl_s && scl_d && !sda_d && sda_s;

  always_comb
  begin
    sync_next = {scl_in, sync_reg[5:4], sda_in, sync_reg[2:1]};
  end

  // ==========================================
  // Byte engine
  always_comb
  begin
    st_next = st_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    byte_next = byte_reg;
    rw_next = rw_reg;
    addr_next = addr_reg;
    hi_next = hi_reg;
    oe_next = oe_reg;
    bus_next = bus_reg;
    bus_next.wr = 1'b0;
    load = 1'b0;
    if (start)
    begin
      st_next = S_RX;
      bit_next = 4'h0;
      byte_next = 2'h0;
      oe_next = 1'b0;
    end
    else if (stop)
    begin
      st_next = S_IDLE;
      oe_next = 1'b0;
    end
    else
    begin
      unique case (st_reg)
        S_IDLE:
        begin
        end
        S_RX:
        begin
          if (rise)
          begin
            sh_next = {sh_reg[6:0], sda_s};
            bit_next = bit_reg + 4'h1;
          end
          else if (fall && bit_reg == 4'h8)
          begin
            st_next = S_ACK;
            oe_next = 1'b1;
            bit_next = 4'h0;
            unique case (byte_reg)
              2'h0:
              begin
                rw_next = sh_reg[0];
                byte_next = sh_reg[0] ? 2'h2 : 2'h1;
                if (sh_reg[7:1] != DEV_ADDR)
                begin
                  st_next = S_IDLE;
                  oe_next = 1'b0;
                end
              end
              2'h1:
              begin
                addr_next = sh_reg;
                byte_next = 2'h2;
              end
              2'h2:
              begin
                hi_next = sh_reg;
                byte_next = 2'h3;
              end
              2'h3:
              begin
                bus_next.wr = 1'b1;
                bus_next.addr = addr_reg;
                bus_next.wdata = {hi_reg, sh_reg};
                addr_next = addr_reg + 8'h01;
                byte_next = 2'h2;
              end
            endcase
          end
        end
        S_ACK:
        begin
          if (fall)
          begin
            oe_next = 1'b0;
            bit_next = 4'h0;
            if (rw_reg)
            begin
              load = 1'b1;
            end
            else
            begin
              st_next = S_RX;
            end
          end
        end
        S_TX:
        begin
          if (fall)
          begin
            bit_next = bit_reg + 4'h1;
            sh_next = {sh_reg[6:0], 1'b0};
            oe_next = !sh_reg[6];
            if (bit_reg == 4'h7)
            begin
              st_next = S_RACK;
              oe_next = 1'b0;
            end
          end
        end
        S_RACK:
        begin
          if (rise && sda_s)
          begin
            st_next = S_IDLE;
          end
          else if (fall)
          begin
            bit_next = 4'h0;
            load = 1'b1;
          end
        end
      endcase
    end
    // A word is sent high byte first; the low byte is held so a later write cannot tear it.
    if (load)
    begin
      st_next = S_TX;
      if (byte_reg == 2'h2)
      begin
        sh_next = rd_data_in[15:8];
        hi_next = rd_data_in[7:0];
        oe_next = !rd_data_in[15];
        byte_next = 2'h3;
      end
      else
      begin
        sh_next = hi_reg;
        oe_next = !hi_reg[7];
        addr_next = addr_reg + 8'h01;
        byte_next = 2'h2;
      end
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      sync_reg <= 6'h3F;
      st_reg <= S_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      byte_reg <= 2'h0;
      rw_reg <= 1'b0;
      addr_reg <= 8'h00;
      hi_reg <= 8'h00;
      oe_reg <= 1'b0;
      bus_reg <= '0;
    end
    else
    begin
      sync_reg <= sync_next;
      st_reg <= st_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      byte_reg <= byte_next;
      rw_reg <= rw_next;
      addr_reg <= addr_next;
      hi_reg <= hi_next;
      oe_reg <= oe_next;
      bus_reg <= bus_next;
    end
  end

  assign sda_oe_out = oe_reg;
  assign bus_out = bus_reg;
  assign rd_addr_out = addr_reg;
endmodule

// File: verilog/bcm_regs.sv
`timescale 1ns/10ps
`include "bcm_params.svh"
// Function
// R1: Mode codes: pass, forced, adaptive one, two.
// R2: Mode field resets to code two.
// R3: Qualify field picks eight deglitch times.
// R4: Qualify field resets to code six.
// R5: Ceiling code n means 6.5V plus n/4.
// R6: Ceiling field resets to code eight.
// R7: Read-only supply code, resets to 0x263.
// R8: Read-only die heat code, resets 0x19.
// R9: Adaptive: above raise level, raise rail.
// R10: Adaptive: below drop level, never raise.
// R11: Drop rail only after full qualify time.
// R12: Reserved bits read zero, writes ignored.
module bcm_regs
  import bcm_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A,
  parameter int unsigned QUAL_CYC [8] = '{
    `BCM_TDEG0_US * `BCM_CLK_MHZ, `BCM_TDEG1_US * `BCM_CLK_MHZ,
    `BCM_TDEG2_US * `BCM_CLK_MHZ, `BCM_TDEG3_US * `BCM_CLK_MHZ,
    `BCM_TDEG4_US * `BCM_CLK_MHZ, `BCM_TDEG5_US * `BCM_CLK_MHZ,
    `BCM_TDEG6_US * `BCM_CLK_MHZ, `BCM_TDEG7_US * `BCM_CLK_MHZ}
)
(
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [6:0] sig_level_in,
  input wire logic [5:0] raise_level_code_in,
  input wire logic [5:0] drop_level_code_in,
  input wire logic meas_valid_in,
  input wire logic [9:0] supply_measure_code_in,
  input wire logic [9:0] die_heat_code_in,
  output bcm_boost_type boost_out
);
  // ==========================================
  // Declarations
  bcm_regbus_type bus;
  logic [7:0] rd_addr;
  logic [15:0] rd_data;
  logic [2:0] mode_reg, mode_next;
  logic [2:0] tdeg_reg, tdeg_next;
  logic [3:0] ceil_reg, ceil_next;
  logic [9:0] supply_reg, supply_next;
  logic [9:0] heat_reg, heat_next;
  logic raise_reg, raise_next;
  logic [29:0] qcnt_reg, qcnt_next;
  logic [29:0] qlim;

  function automatic logic is_adaptive(input logic [2:0] m);
    is_adaptive = (m == BCM_MODE_ADAPT1) || (m == BCM_MODE_ADAPT2);
  endfunction

  // Unmapped offsets and reserved bits read as zero.
  function automatic logic [15:0] read_word(input logic [7:0] a);
    read_word = 16'h0000;
    unique case (a)
      `BCM_ADDR_MODE: read_word = {9'h000, mode_reg, 1'b0, tdeg_reg}; // R12
      `BCM_ADDR_CEIL: read_word = {12'h000, ceil_reg}; // R5
      `BCM_ADDR_SUPPLY: read_word = {6'h00, supply_reg}; // R7
      `BCM_ADDR_HEAT: read_word = {6'h00, heat_reg}; // R8
      default: read_word = 16'h0000; // R12
    endcase
  endfunction

  // ==========================================
  // Control port
  bcm_i2c_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_port (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe_out(sda_oe_out),
    .bus_out(bus),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data)
  );

  assign rd_data = read_word(rd_addr);
  assign sda_out = 1'b0;

  // ==========================================
  // Register file
  always_comb
  begin
    mode_next = mode_reg;
    tdeg_next = tdeg_reg;
    ceil_next = ceil_reg;
    supply_next = supply_reg;
    heat_next = heat_reg;
    if (bus.wr && bus.addr == `BCM_ADDR_MODE)
    begin
      mode_next = bus.wdata[`BCM_MODE_MSB:`BCM_MODE_LSB]; // R1
      tdeg_next = bus.wdata[`BCM_TDEG_MSB:0]; // R3
    end
    if (bus.wr && bus.addr == `BCM_ADDR_CEIL)
    begin
      ceil_next = bus.wdata[`BCM_CEIL_MSB:0]; // R5
    end
    // Writes to the readout offsets fall through; only the monitors update them.
    if (meas_valid_in)
    begin
      supply_next = supply_measure_code_in[`BCM_MEAS_MSB:0]; // R7
      heat_next = die_heat_code_in[`BCM_MEAS_MSB:0]; // R8
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      mode_reg <= `BCM_MODE_RST; // R2
      tdeg_reg <= `BCM_TDEG_RST; // R4
      ceil_reg <= `BCM_CEIL_RST; // R6
      supply_reg <= `BCM_SUPPLY_RST; // R7
      heat_reg <= `BCM_HEAT_RST; // R8
    end
    else
    begin
      mode_reg <= mode_next;
      tdeg_reg <= tdeg_next;
      ceil_reg <= ceil_next;
      supply_reg <= supply_next;
      heat_reg <= heat_next;
    end
  end

  // ==========================================
  // Adaptive boost decision
  assign qlim = 30'(QUAL_CYC[tdeg_reg]); // R3

  // Between the two levels the rail holds, so a hovering signal cannot chatter.
  always_comb
  begin
    raise_next = 1'b0;
    qcnt_next = 30'h0;
    if (mode_reg == BCM_MODE_FORCE)
    begin
      raise_next = 1'b1; // R1
    end
    else if (is_adaptive(mode_reg))
    begin
      if (sig_level_in > {1'b0, raise_level_code_in})
      begin
        raise_next = 1'b1; // R9
      end
      else if (sig_level_in < {1'b0, drop_level_code_in})
      begin
        qcnt_next = (qcnt_reg >= qlim) ? qlim : qcnt_reg + 30'h1; // R11
        raise_next = raise_reg && (qcnt_next != qlim); // R10
      end
      else
      begin
        raise_next = raise_reg; // R11
      end
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      raise_reg <= 1'b0;
      qcnt_reg <= 30'h0;
    end
    else
    begin
      raise_reg <= raise_next;
      qcnt_reg <= qcnt_next;
    end
  end

  assign boost_out = '{mode_reg, tdeg_reg, ceil_reg, raise_reg};

  // ==========================================
  // Assertions
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_small;
    is_adaptive(mode_reg) && sig_level_in < {1'b0, drop_level_code_in};
  endsequence

  property p_reset_fields;
    $rose(nrst_in) |-> mode_reg == 3'h2 && tdeg_reg == 3'h6 && ceil_reg == 4'h8;
  endproperty
  a_reset_fields: assert property (p_reset_fields) else $error("Field reset wrong."); // R2

  property p_reset_meas;
    $rose(nrst_in) |-> supply_reg == 10'h263 && heat_reg == 10'h19;
  endproperty
  a_reset_meas: assert property (p_reset_meas) else $error("Readout reset wrong."); // R7

  property p_force;
    mode_reg == BCM_MODE_FORCE |=> raise_reg;
  endproperty
  a_force: assert property (p_force) else $error("Forced mode not raised."); // R1

  property p_pass;
    mode_reg == BCM_MODE_PASS |=> !raise_reg;
  endproperty
  a_pass: assert property (p_pass) else $error("Pass mode raised."); // R1

  property p_attack;
    is_adaptive(mode_reg) && sig_level_in > {1'b0, raise_level_code_in} |=> raise_reg;
  endproperty
  a_attack: assert property (p_attack) else $error("Attack did not raise."); // R9

  property p_release_hold;
    s_small and !raise_reg |=> !raise_reg;
  endproperty
  a_release_hold: assert property (p_release_hold) else $error("Raised below drop level."); // R10

  property p_qualify;
    $fell(raise_reg) && is_adaptive($past(mode_reg)) |-> qcnt_reg == qlim;
  endproperty
  a_qualify: assert property (p_qualify) else $error("Rail dropped early."); // R11

  property p_restart;
    is_adaptive(mode_reg) && sig_level_in >= {1'b0, drop_level_code_in} |=> qcnt_reg == 30'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("Qualify count kept."); // R11

  property p_reserved;
    rd_addr == `BCM_ADDR_MODE |-> rd_data[15:7] == 9'h000 && rd_data[3] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bit set."); // R12

  // Holes in the map must not leak another register onto the port.
  property p_unmapped;
    !(rd_addr inside {`BCM_ADDR_MODE, `BCM_ADDR_CEIL, `BCM_ADDR_SUPPLY, `BCM_ADDR_HEAT})
      |-> rd_data == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero."); // R12
endmodule

// File: bench/bcm_i2c_host.sv
`timescale 1ns/10ps
module bcm_i2c_host
#(
  parameter logic [6:0] DEV = 7'h2A,
  parameter int HALF = 6
)
(
  input wire logic ref_clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out
);
  // ==========================================
  // Bus phases
  // Each phase is longer than the device minimum so its synchroniser lag always fits.
  int nack_count = 0;
  initial
  begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic wt();
    repeat (HALF) @(negedge ref_clk_in);
  endtask
  task automatic xbit(input logic tx, output logic rx);
    sda_oe_out = ~tx;
    wt();
    scl_out = 1'b1;
    wt();
    rx = sda_in;
    scl_out = 1'b0;
    wt();
  endtask
  task automatic xbyte(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
                       output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      xbit(tx[i], rx[i]);
    end
    xbit(ack_tx, ack);
  endtask
  task automatic wbyte(input logic [7:0] b);
    logic [7:0] rx;
    logic ack;
    xbyte(b, 1'b1, rx, ack);
    nack_count += int'(ack);
  endtask
  task automatic start_cond();
    sda_oe_out = 1'b0;
    wt();
    scl_out = 1'b1;
    wt();
    sda_oe_out = 1'b1;
    wt();
    scl_out = 1'b0;
    wt();
  endtask
  task automatic stop_cond();
    sda_oe_out = 1'b1;
    wt();
    scl_out = 1'b1;
    wt();
    sda_oe_out = 1'b0;
    wt();
  endtask
  // ==========================================
  // Register transfers
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [15:0] d);
    start_cond();
    wbyte({dev, 1'b0});
    wbyte(a);
    wbyte(d[15:8]);
    wbyte(d[7:0]);
    stop_cond();
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    logic [7:0] hi;
    logic [7:0] lo;
    logic ack;
    start_cond();
    wbyte({DEV, 1'b0});
    wbyte(a);
    start_cond();
    wbyte({DEV, 1'b1});
    xbyte(8'hFF, 1'b0, hi, ack);
    xbyte(8'hFF, 1'b1, lo, ack);
    stop_cond();
    d = {hi, lo};
  endtask
endmodule

// File: bench/tb_boost_control_monitor_regs.sv
`timescale 1ns/10ps
module tb_boost_control_monitor_regs;
  import bcm_pkg::*;
  // ==========================================
  // Harness
  localparam int unsigned QC [8] = '{4, 5, 6, 7, 8, 9, 10, 11};
  localparam logic [2:0] MODES [5] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h3};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic scl;
  logic host_oe;
  logic dut_sda;
  logic dut_oe;
  logic sda_line;
  logic [6:0] sig = 7'h00;
  logic [5:0] atk = 6'h14;
  logic [5:0] rel = 6'h0A;
  logic meas_valid = 1'b0;
  logic [9:0] supply = 10'h000;
  logic [9:0] heat = 10'h000;
  bcm_boost_type boost;
  int bad_count = 0;
  int comparisons = 0;
  int seed = 8;
  logic [15:0] word;
  logic [2:0] m;
  logic [2:0] q;
  logic [3:0] c;
  always #2.5 clk = ~clk;
  // The pull-up wins unless one side pulls the data line low.
  assign sda_line = ~host_oe & (~dut_oe | dut_sda);
  bcm_regs #(.DEV_ADDR(7'h2A), .QUAL_CYC(QC)) u_dut (
    .ref_clk_in(clk), .nrst_in(nrst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(dut_sda), .sda_oe_out(dut_oe), .sig_level_in(sig),
    .raise_level_code_in(atk), .drop_level_code_in(rel), .meas_valid_in(meas_valid),
    .supply_measure_code_in(supply), .die_heat_code_in(heat), .boost_out(boost));
  bcm_i2c_host #(.DEV(7'h2A), .HALF(6)) u_host (
    .ref_clk_in(clk), .sda_in(sda_line), .scl_out(scl), .sda_oe_out(host_oe));
  // ==========================================
  // Helpers
  function automatic int rnd(input int n);
    return int'({$random(seed)} % n);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    u_host.read_reg(a, v);
    check(v, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_host.write_reg(7'h2A, a, d);
    cyc(4);
  endtask
  // Level zero is below the drop code, one between the codes, two above the raise code.
  task automatic lvl(input int k);
    sig = (k == 0) ? 7'(rnd(int'(rel))) :
          (k == 1) ? 7'(int'(rel) + 1 + rnd(int'(atk - rel) - 1)) :
          7'(int'(atk) + 1 + rnd(40));
  endtask
  task automatic do_reset();
    nrst = 1'b0;
    cyc(20);
    nrst = 1'b1;
    cyc(3);
    check(16'(boost.converter_operating_select), 16'h0002);
    check(16'(boost.small_signal_qualify_time), 16'h0006);
    check(16'(boost.rail_ceiling_code), 16'h0008);
  endtask
  // ==========================================
  // Sequence
  initial
  begin
    do_reset();
    rd_chk(8'h61, 16'h0026);
    rd_chk(8'h62, 16'h0008);
    rd_chk(8'h6D, 16'h0263);
    rd_chk(8'h6E, 16'h0019);
    rd_chk(8'h70, 16'h0000);
    lvl(2);
    for (int i = 0; i < 5; i++)
    begin
      m = MODES[i];
      word = 16'(rnd(65536));
      word[6:4] = m;
      q = word[2:0];
      wr(8'h61, word);
      check(16'(boost.converter_operating_select), 16'(m));
      check(16'(boost.small_signal_qualify_time), 16'(q));
      check(16'(boost.raise_rail), 16'(m inside {3'h1, 3'h5, 3'h6}));
      rd_chk(8'h61, {9'h000, m, 1'b0, q});
    end
    for (int i = 0; i < 4; i++)
    begin
      c = (i == 0) ? 4'hF : (i == 1) ? 4'h0 : 4'(rnd(16));
      word = 16'(rnd(65536));
      word[3:0] = c;
      wr(8'h62, word);
      check(16'(boost.rail_ceiling_code), 16'(c));
      rd_chk(8'h62, {12'h000, c});
    end
    check(16'(u_host.nack_count), 16'h0000);
    u_host.write_reg(7'h2B, 8'h62, 16'h0003);
    check(16'(u_host.nack_count), 16'h0004);
    rd_chk(8'h62, {12'h000, c});
    wr(8'h6D, 16'hFFFF);
    wr(8'h6E, 16'hFFFF);
    rd_chk(8'h6D, 16'h0263);
    rd_chk(8'h6E, 16'h0019);
    meas_valid = 1'b1;
    supply = 10'(rnd(1024));
    heat = 10'h3D8;
    cyc(1);
    meas_valid = 1'b0;
    word = {6'h00, supply};
    supply = ~supply;
    heat = 10'h000;
    rd_chk(8'h6D, word);
    rd_chk(8'h6E, 16'h03D8);
    for (int i = 0; i < 2; i++)
    begin
      m = i ? 3'h6 : 3'h5;
      q = i ? 3'h7 : 3'h0;
      rel = 6'(4 + rnd(8));
      atk = rel + 6'(2 + rnd(8));
      wr(8'h61, {9'h000, m, 1'b0, q});
      lvl(2);
      cyc(2);
      check(16'(boost.raise_rail), 16'h0001);
      lvl(0);
      cyc(QC[q] - 2);
      check(16'(boost.raise_rail), 16'h0001);
      lvl(1);
      cyc(2);
      lvl(0);
      cyc(QC[q] - 1);
      check(16'(boost.raise_rail), 16'h0001);
      cyc(1);
      check(16'(boost.raise_rail), 16'h0000);
      cyc(4);
      check(16'(boost.raise_rail), 16'h0000);
      cyc(QC[q]);
      check(16'(boost.raise_rail), 16'h0000);
      lvl(1);
      cyc(3);
      check(16'(boost.raise_rail), 16'h0000);
    end
    do_reset();
    report_and_stop();
  end
  initial
  begin
    cyc(90000);
    bad_count++;
    $display("Error at %0t: run did not finish in time", $time);
    report_and_stop();
  end
endmodule
